// [rtl/bwi_top.sv]
// boot-complete pulse and wake-state indication on two irq pins
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module bwi_top import bwi_pkg::*; #(
  parameter int SHORT_CYC = BWI_SHORT_CYC,
  parameter int LONG_CYC  = BWI_LONG_CYC
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [1:0]       avs_response_out,
  // pins and state from the rest of the device
  input  wire logic        bootstrap_strap_pin_in,
  input  wire logic [1:0]  sys_mode_in,
  input  wire logic        other_irq_a_in,
  input  wire logic        other_irq_b_in,
  // interrupt pins, open-drain style enable for pin b in strap mode
  output logic             irq_pin_a_out,
  output logic             irq_pin_b_out,
  output logic             irq_pin_b_oe_out,
  // host interrupt
  output logic             irq_out
);
  localparam int CW = 32;

  // synchronised pins
  logic       strap_s;
  logic [1:0] mode_s;
  logic       oth_a_s;
  logic       oth_b_s;

  bwi_pin_sync #(.W(5)) u_sync (
    .clk_in   (core_clk_in),
    .rst_in   (rst_in),
    .async_in ({bootstrap_strap_pin_in, sys_mode_in,
                other_irq_a_in, other_irq_b_in}),
    .sync_out ({strap_s, mode_s, oth_a_s, oth_b_s})
  );

  // strap captured after reset release; held until next power cycle
  // synchroniser is cleared by reset, so wait until it holds the pin
  logic       strap_q;
  logic       strap_valid_q;
  logic [1:0] settle_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      strap_valid_q <= 1'b0;
      strap_q       <= 1'b0;
      settle_q      <= 2'h0;
    end else if (!strap_valid_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == 2'h2) begin
        strap_valid_q <= 1'b1;
        strap_q       <= strap_s;
      end
    end
  end

  // registers
  logic [7:0] int_en_q;
  logic [7:0] pin_sel_q;
  logic       polarity_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_mask_q;
  logic       startup_irq_suppress_q;
  logic       soft_pend_q;
  logic       boot_busy;
  logic       in_wake;

  logic        acc_q;
  logic        wr_hit;
  logic        rd_hit;
  logic        cmd_boot;
  logic        cmd_soft;
  logic        cmd_hib;
  logic [2:0]  ev;

  function automatic logic mapped(input logic [7:0] a);
    return a == BWI_ADDR_INT_EN || a == BWI_ADDR_PIN_SEL ||
           a == BWI_ADDR_CONFIG || a == BWI_ADDR_STATUS ||
           a == BWI_ADDR_IRQ_ST || a == BWI_ADDR_IRQ_MASK ||
           a == BWI_ADDR_CMD;
  endfunction

  // one wait cycle per access: answer on the second edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= (avs_read_in || avs_write_in) && !acc_q;
    end
  end

  assign wr_hit = acc_q && avs_write_in && avs_byteenable_in[0];
  assign rd_hit = acc_q && avs_read_in;
  assign cmd_boot = wr_hit && avs_address_in == BWI_ADDR_CMD &&
                    avs_writedata_in[BWI_BIT_CMD_BOOT];
  assign cmd_soft = wr_hit && avs_address_in == BWI_ADDR_CMD &&
                    avs_writedata_in[BWI_BIT_CMD_SOFT];
  assign cmd_hib  = wr_hit && avs_address_in == BWI_ADDR_CMD &&
                    avs_writedata_in[BWI_BIT_CMD_HIB];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= '0;
      avs_response_out    <= 2'h0;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !acc_q);
      if ((avs_read_in || avs_write_in) && !acc_q) begin
        avs_response_out <= mapped(avs_address_in) ? 2'h0 : 2'h2;
        avs_readdata_out <= '0;
        if (avs_read_in) begin
          unique case (avs_address_in)
            // boot disable lives apart so soft reset cannot clear it
            BWI_ADDR_INT_EN:   avs_readdata_out[7:0] <= {int_en_q[7:2],
                                 startup_irq_suppress_q, int_en_q[0]};
            BWI_ADDR_PIN_SEL:  avs_readdata_out[7:0] <= pin_sel_q;
            BWI_ADDR_CONFIG:   avs_readdata_out[0]   <= polarity_q;
            BWI_ADDR_STATUS:   avs_readdata_out[4:0] <= {boot_busy,
                                 strap_q, mode_s, in_wake};
            BWI_ADDR_IRQ_ST:   avs_readdata_out[2:0] <= irq_st_q;
            BWI_ADDR_IRQ_MASK: avs_readdata_out[2:0] <= irq_mask_q;
            default:           avs_readdata_out      <= '0;
          endcase
        end
      end
    end
  end

  // boot disable survives soft reset, cleared by power-on or hibernate
  always_ff @(posedge core_clk_in) begin
    if (rst_in || cmd_hib) begin
      startup_irq_suppress_q <= 1'b0;
    end else if (wr_hit && avs_address_in == BWI_ADDR_INT_EN) begin
      startup_irq_suppress_q <= avs_writedata_in[BWI_BIT_STARTUP_IRQ_SUPPRESS];
    end
  end

  // soft reset returns enable, routing, polarity and mask to defaults; boot disable and event status kept
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      int_en_q   <= BWI_INT_EN_RST_GND;
      pin_sel_q  <= BWI_PIN_SEL_RST;
      polarity_q <= 1'b0;
      irq_mask_q <= '0;
    end else if (cmd_soft || cmd_hib || !strap_valid_q) begin
      int_en_q   <= strap_s ? BWI_INT_EN_RST_VDD : BWI_INT_EN_RST_GND;
      pin_sel_q  <= BWI_PIN_SEL_RST;
      polarity_q <= 1'b0;
      irq_mask_q <= '0;
    end else if (wr_hit) begin
      unique case (avs_address_in)
        BWI_ADDR_INT_EN:   int_en_q   <= avs_writedata_in[7:0];
        BWI_ADDR_PIN_SEL:  pin_sel_q  <= avs_writedata_in[7:0];
        BWI_ADDR_CONFIG:   polarity_q <= avs_writedata_in[BWI_BIT_POL];
        BWI_ADDR_IRQ_MASK: irq_mask_q <= avs_writedata_in[2:0];
        default: ;
      endcase
    end
  end

  // boot request: after reset settle, on soft reset, or by command
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      soft_pend_q <= 1'b0;
    end else begin
      // first boot only once the strap is known, so length and pin fit
      soft_pend_q <= cmd_soft || cmd_boot ||
                     (!strap_valid_q && settle_q == 2'h2);
    end
  end

  logic startup_irq_suppress_eff;
  logic boot_done;
  logic [CW-1:0] boot_len;
  assign startup_irq_suppress_eff = strap_q ? 1'b0 : startup_irq_suppress_q;
  assign boot_len = strap_q ? CW'(LONG_CYC) : CW'(SHORT_CYC);

  bwi_pulse_gen #(.CNT_W(CW)) u_pulse (
    .clk_in     (core_clk_in),
    .rst_in     (rst_in),
    .start_in   (soft_pend_q),
    .len_in     (boot_len),
    .active_out (boot_busy),
    .done_out   (boot_done)
  );

  // wake indication
  logic in_wake_q;
  logic wake_show;
  logic wake_b;
  logic boot_show;
  logic boot_b;
  assign in_wake   = (mode_s == BWI_MODE_WAKE);
  assign wake_show = int_en_q[BWI_BIT_WAKE_EN] && in_wake;
  assign wake_b    = pin_sel_q[BWI_BIT_WAKE_B];
  assign boot_show = boot_busy && !startup_irq_suppress_eff;
  assign boot_b    = strap_q ? 1'b1 : pin_sel_q[BWI_BIT_BOOT_B];

  // sticky events, write one to clear, set wins
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      in_wake_q <= 1'b0;
    end else begin
      in_wake_q <= in_wake;
    end
  end
  assign ev[BWI_EV_BOOT_DONE]  = boot_done;
  assign ev[BWI_EV_WAKE_ENTER] = in_wake && !in_wake_q;
  assign ev[BWI_EV_WAKE_LEAVE] = !in_wake && in_wake_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_st_q <= '0;
    end else if (wr_hit && avs_address_in == BWI_ADDR_IRQ_ST) begin
      irq_st_q <= (irq_st_q & ~avs_writedata_in[2:0]) | ev;
    end else begin
      irq_st_q <= irq_st_q | ev;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_st_q & irq_mask_q);
    end
  end

  // pin drive; active level when polarity 1 is high
  logic act_a;
  logic act_b;
  always_comb begin
    act_a = 1'b0;
    act_b = 1'b0;
    if (boot_show) begin
      if (boot_b) act_b = 1'b1;
      else        act_a = 1'b1;
    end
    if (wake_show) begin
      if (wake_b) act_b = 1'b1;
      else        act_a = 1'b1;
    end
    // other sources on pin b dropped in strap mode
    if (!strap_q) begin
      act_a = act_a | oth_a_s;
      act_b = act_b | oth_b_s;
    end else begin
      act_a = act_a | oth_a_s;
    end
  end

  // pins stay released until the strap decides how pin b is driven
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !strap_valid_q) begin
      irq_pin_a_out    <= 1'b1;
      irq_pin_b_out    <= 1'b1;
      irq_pin_b_oe_out <= 1'b0;
    end else if (strap_q) begin
      // pin b open drain, active low
      irq_pin_a_out    <= act_a ^ ~polarity_q;
      irq_pin_b_out    <= 1'b0;
      irq_pin_b_oe_out <= boot_show;
    end else begin
      irq_pin_a_out    <= act_a ^ ~polarity_q;
      irq_pin_b_out    <= act_b ^ ~polarity_q;
      irq_pin_b_oe_out <= 1'b1;
    end
  end
endmodule // bwi_top

// [rtl/bwi_pkg.sv]
// package for the boot and wake interrupt output block
// Behaviour
// - boot irq enabled when disable bit clear
// - boot irq is a pulse at configured polarity when strap low
// - disable bit set suppresses boot irq when strap low
// - strap low: short pulse on selected pin
// - strap high: ignore disable, long low pulse pin b
// - disable bit kept until power loss or hibernate
// - soft reset keeps the disable bit
// - wake output enable clear: no wake indication
// - wake state 01b holds pin at active level
// - wake level steady for whole wake state
// - leaving wake drives pin to inactive level
// - strap high: other sources on pin b ignored
// - routing bit 1 steers boot irq a/b
// - routing bit 0 steers wake output a/b
package bwi_pkg;
  localparam logic [7:0] BWI_ADDR_INT_EN   = 8'h20;
  localparam logic [7:0] BWI_ADDR_PIN_SEL  = 8'h21;
  localparam logic [7:0] BWI_ADDR_CONFIG   = 8'h40;
  localparam logic [7:0] BWI_ADDR_STATUS   = 8'h44;
  localparam logic [7:0] BWI_ADDR_IRQ_ST   = 8'h48;
  localparam logic [7:0] BWI_ADDR_IRQ_MASK = 8'h4C;
  localparam logic [7:0] BWI_ADDR_CMD      = 8'h50;
  localparam int BWI_BIT_STARTUP_IRQ_SUPPRESS  = 1;
  localparam int BWI_BIT_WAKE_EN   = 0;
  localparam int BWI_BIT_BOOT_B    = 1;
  localparam int BWI_BIT_WAKE_B    = 0;
  localparam int BWI_BIT_POL       = 0;
  localparam int BWI_BIT_CMD_BOOT  = 0;
  localparam int BWI_BIT_CMD_SOFT  = 1;
  localparam int BWI_BIT_CMD_HIB   = 2;
  localparam int BWI_EV_BOOT_DONE  = 0;
  localparam int BWI_EV_WAKE_ENTER = 1;
  localparam int BWI_EV_WAKE_LEAVE = 2;
  localparam logic [7:0] BWI_INT_EN_RST_GND = 8'h00;
  localparam logic [7:0] BWI_INT_EN_RST_VDD = 8'h20;
  localparam logic [7:0] BWI_PIN_SEL_RST    = 8'h00;
  localparam logic [1:0] BWI_MODE_WAKE      = 2'h1;
  localparam int BWI_CLK_MHZ     = 200;
  localparam int BWI_T_SHORT_US  = 20;
  localparam int BWI_T_LONG_MS   = 10;
  localparam int BWI_SHORT_CYC   = BWI_T_SHORT_US * BWI_CLK_MHZ;
  localparam int BWI_LONG_CYC    = BWI_T_LONG_MS * 1000 * BWI_CLK_MHZ;

  typedef enum logic [1:0] {
    BWI_ST_IDLE  = 2'b00,
    BWI_ST_PULSE = 2'b01,
    BWI_ST_DONE  = 2'b10
  } bwi_state_t;

  typedef struct packed {
    logic a;
    logic b;
  } bwi_pins_t;

  typedef struct packed {
    logic       boot_req;
    logic       strap_vdd;
    logic       polarity;
    logic       route_b;
  } bwi_boot_cfg_t;
endpackage

// [rtl/bwi_pulse_gen.sv]
// boot pulse timer: one pulse of programmable length per request taken while idle; requests during a pulse are dropped
`timescale 1ns/1ps
module bwi_pulse_gen import bwi_pkg::*; #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // control
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] len_in,
  // status
  output logic                  active_out,
  output logic                  done_out
);
  bwi_state_t       state_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= BWI_ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        BWI_ST_IDLE: begin
          if (start_in) begin
            state_q <= BWI_ST_PULSE;
            cnt_q   <= len_in;
          end
        end
        BWI_ST_PULSE: begin
          if (cnt_q <= CNT_W'(1)) begin
            state_q <= BWI_ST_DONE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        BWI_ST_DONE: state_q <= BWI_ST_IDLE;
        default:     state_q <= BWI_ST_IDLE;
      endcase
    end
  end

  assign active_out = (state_q == BWI_ST_PULSE);
  assign done_out   = (state_q == BWI_ST_DONE);
endmodule // bwi_pulse_gen

// [rtl/bwi_pin_sync.sv]
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module bwi_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // bwi_pin_sync

// [test/bwi_host_model.sv]
// host side model: times the pulses seen on both irq pins
`timescale 1ns/1ps
module bwi_host_model (
  // clock and control
  input  wire logic clk_in,
  input  wire logic clr_in,
  input  wire logic act_in,
  // pin levels as the host sees them, nothing routed back
  input  wire logic pin_a_in,
  input  wire logic pin_b_in,
  // measurements
  output int        len_a_out,
  output int        len_b_out,
  output int        n_a_out,
  output int        n_b_out
);
  int run_a;
  int run_b;
  // a run counts only when it ends, so a held level shows no pulse
  always @(posedge clk_in) begin
    if (clr_in) begin
      run_a = 0;
      run_b = 0;
      n_a_out = 0;
      n_b_out = 0;
    end else begin
      if (pin_a_in === act_in) begin
        run_a++;
      end else if (run_a > 0) begin
        len_a_out = run_a;
        n_a_out++;
        run_a = 0;
      end
      if (pin_b_in === act_in) begin
        run_b++;
      end else if (run_b > 0) begin
        len_b_out = run_b;
        n_b_out++;
        run_b = 0;
      end
    end
  end
endmodule // bwi_host_model

// [test/bwi_top_asserts.sv]
// port assertions for the boot and wake irq block
`timescale 1ns/1ps
module bwi_top_asserts import bwi_pkg::*; #(
  parameter int LONG_CYC = 50
) (
  // clock, reset and bus
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  avs_response_out,
  // pins
  input wire logic        bootstrap_strap_pin_in,
  input wire logic        other_irq_b_in,
  input wire logic        irq_pin_b_out,
  input wire logic        irq_pin_b_oe_out
);
  logic [31:0] oe_run_q;
  logic        mapped;
  assign mapped = avs_address_in inside {BWI_ADDR_INT_EN, BWI_ADDR_PIN_SEL,
    BWI_ADDR_CONFIG, BWI_ADDR_STATUS, BWI_ADDR_IRQ_ST, BWI_ADDR_IRQ_MASK,
    BWI_ADDR_CMD};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !irq_pin_b_oe_out || !bootstrap_strap_pin_in) begin
      oe_run_q <= '0;
    end else begin
      oe_run_q <= oe_run_q + 32'h1;
    end
  end
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_answer;
    s_req |=> s_ans;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer off");
  property p_unmapped;
    !avs_waitrequest_out && avs_read_in && !mapped
      |-> avs_response_out == 2'h2 && avs_readdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
  property p_ok;
    !avs_waitrequest_out && mapped |-> avs_response_out == 2'h0;
  endproperty
  a_ok: assert property (p_ok) else $error("bad response");
  property p_oe_low;
    irq_pin_b_oe_out && bootstrap_strap_pin_in |-> !irq_pin_b_out;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("b driven high");
  property p_long;
    $fell(irq_pin_b_oe_out) && bootstrap_strap_pin_in
      |-> oe_run_q == LONG_CYC;
  endproperty
  a_long: assert property (p_long) else $error("long pulse width");
  property p_oe_max;
    oe_run_q <= LONG_CYC;
  endproperty
  a_oe_max: assert property (p_oe_max) else $error("long pulse over");
  property p_oe_strap;
    !bootstrap_strap_pin_in && $past(irq_pin_b_oe_out) |-> irq_pin_b_oe_out;
  endproperty
  a_oe_strap: assert property (p_oe_strap) else $error("b not driven");
  property p_strap_ign;
    bootstrap_strap_pin_in && other_irq_b_in && !irq_pin_b_oe_out
      |=> !irq_pin_b_oe_out [*3];
  endproperty
  a_strap_ign: assert property (p_strap_ign) else $error("b not ignored");
endmodule // bwi_top_asserts

// [test/testbench.sv]
// self-checking bench for the boot and wake irq block
`timescale 1ns/1ps
module testbench;
  import bwi_pkg::*;
  localparam int SHORT = 20;
  localparam int LONG  = 50;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  logic [1:0]  resp, rs;
  logic        wait_o, pa, pb, pb_oe, irq, pb_w, x;
  logic        strap = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        oth_b = 1'b0;
  logic        clr = 1'b1;
  logic        pol = 1'b0;
  int          len_a, len_b, n_a, n_b;
  int          fail_count = 0;
  int          tests_run = 0;
  always #2.5 clk = ~clk;
  // pull-up holds b high while the strap mode releases it
  assign pb_w = (pb_oe || !strap) ? pb : 1'b1;
  bwi_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (
    .core_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_o), .avs_response_out(resp),
    .bootstrap_strap_pin_in(strap), .sys_mode_in(mode),
    .other_irq_a_in(1'b0),
    .other_irq_b_in(oth_b), .irq_pin_a_out(pa), .irq_pin_b_out(pb),
    .irq_pin_b_oe_out(pb_oe), .irq_out(irq));
  bwi_host_model host (.clk_in(clk), .clr_in(clr), .act_in(pol),
    .pin_a_in(pa), .pin_b_in(pb_w), .len_a_out(len_a), .len_b_out(len_b),
    .n_a_out(n_a), .n_b_out(n_b));
  task automatic close_out();
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wait_o === 1'b0) break;
    end
    q = rdata;
    rs = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n == 20) begin
      fail_count++;
      close_out();
    end
  endtask
  // settle time first so a level change is not taken for a pulse
  task automatic clear_model();
    wcyc(4);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic do_reset(input logic s);
    strap <= s;
    rst <= 1'b1;
    wcyc(20);
    rst <= 1'b0;
    clear_model();
    wcyc(100);
  endtask
  task automatic reboot();
    clear_model();
    bus(1'b1, BWI_ADDR_CMD, 32'h1);
    wcyc(80);
  endtask
  task automatic t_boot_gnd();
    do_reset(1'b0);
    chk(n_a, 32'h1, "one boot pulse on a");
    chk(len_a, SHORT, "short pulse width");
    chk(n_b, 32'h0, "b quiet at boot");
    chk({31'h0, pa}, 32'h1, "a back inactive");
    bus(1'b0, BWI_ADDR_INT_EN, 32'h0);
    chk(q, 32'h0, "enable reset value");
    bus(1'b0, 8'h30, 32'h0);
    chk({q[29:0], rs}, 32'h2, "unmapped read");
  endtask
  task automatic t_route_pol();
    bus(1'b1, BWI_ADDR_PIN_SEL, 32'h2);
    reboot();
    chk({n_a[15:0], n_b[15:0]}, 32'h1, "boot routed to b");
    chk(len_b, SHORT, "b pulse width");
    bus(1'b1, BWI_ADDR_CONFIG, 32'h1);
    pol <= 1'b1;
    reboot();
    chk({n_b[15:0], len_b[15:0]}, {16'h1, 16'(SHORT)}, "high pulse");
    chk({31'h0, pb_w}, 32'h0, "b back low");
    bus(1'b1, BWI_ADDR_CONFIG, 32'h0);
    pol <= 1'b0;
    bus(1'b1, BWI_ADDR_PIN_SEL, 32'h0);
  endtask
  task automatic t_disable();
    bus(1'b1, BWI_ADDR_INT_EN, 32'h2);
    reboot();
    chk(n_a + n_b, 32'h0, "boot suppressed");
    bus(1'b1, BWI_ADDR_CMD, 32'h2);
    wcyc(80);
    bus(1'b0, BWI_ADDR_INT_EN, 32'h0);
    chk(q & 32'h2, 32'h2, "disable kept on soft reset");
    bus(1'b1, BWI_ADDR_CMD, 32'h4);
    wcyc(80);
    bus(1'b0, BWI_ADDR_INT_EN, 32'h0);
    chk(q & 32'h2, 32'h0, "disable lost on hibernate");
  endtask
  task automatic t_wake();
    mode <= BWI_MODE_WAKE;
    wcyc(10);
    chk({30'h0, pa, pb_w}, 32'h3, "no wake output");
    bus(1'b1, BWI_ADDR_INT_EN, 32'h1);
    bus(1'b1, BWI_ADDR_PIN_SEL, 32'h1);
    clear_model();
    wcyc(30);
    chk({30'h0, pa, pb_w}, 32'h2, "wake held on b");
    chk(n_b, 32'h0, "wake level steady");
    mode <= 2'h2;
    wcyc(10);
    chk({n_b[30:0], pb_w}, 32'h3, "wake left");
    bus(1'b0, BWI_ADDR_IRQ_ST, 32'h0);
    chk(q & 32'h6, 32'h6, "wake events latched");
    bus(1'b1, BWI_ADDR_IRQ_MASK, 32'h0);
    wcyc(2);
    x = irq;
    bus(1'b1, BWI_ADDR_IRQ_MASK, 32'h7);
    wcyc(2);
    chk({31'h0, x ^ irq}, 32'h1, "mask gates irq");
    bus(1'b1, BWI_ADDR_IRQ_ST, 32'h7);
    wcyc(2);
    bus(1'b0, BWI_ADDR_IRQ_ST, 32'h0);
    chk({q[2:0], irq}, 32'h0, "events cleared");
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    chk({n_a[15:0], n_b[15:0]}, 32'h1, "strap pulse on b");
    chk(len_b, LONG, "long pulse width");
    bus(1'b0, BWI_ADDR_INT_EN, 32'h0);
    chk(q, {24'h0, BWI_INT_EN_RST_VDD}, "strap reset value");
    bus(1'b1, BWI_ADDR_INT_EN, 32'h3);
    oth_b <= 1'b1;
    mode <= BWI_MODE_WAKE;
    wcyc(30);
    chk({31'h0, pb_w}, 32'h1, "b ignores others");
    oth_b <= 1'b0;
    mode <= 2'h0;
    reboot();
    chk({n_b[15:0], len_b[15:0]}, {16'h1, 16'(LONG)}, "disable ignored");
  endtask
  initial begin
    t_boot_gnd();
    t_route_pol();
    t_disable();
    t_wake();
    t_strap();
    close_out();
  end
  initial begin
    wcyc(20000);
    fail_count++;
    close_out();
  end
endmodule // testbench
bind bwi_top bwi_top_asserts #(.LONG_CYC(LONG_CYC)) u_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out),
  .bootstrap_strap_pin_in(bootstrap_strap_pin_in),
  .other_irq_b_in(other_irq_b_in), .irq_pin_b_out(irq_pin_b_out),
  .irq_pin_b_oe_out(irq_pin_b_oe_out));
